// ### rtl/fba_seq_params.svh
// constants for the fixed-block transfer sequencer
`ifndef FBA_SEQ_PARAMS_SVH
`define FBA_SEQ_PARAMS_SVH
`define BLOCK_BYTES 16'h0200
`define BLOCK_BYTES_ZERO 16'h0000
`define MAX_BLOCKS 16'hFFFF
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8
`define SUB_READ 3'h0
`define SUB_WRITE 3'h1
`define SUB_WRITE_CHECK 3'h2
`define SUB_READ_REPL 3'h3
`define SUB_FORMAT_DEF 3'h4
`endif

// ### rtl/fba_seq_pkg.sv
// types for the fixed-block transfer sequencer
package fba_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SEEK = 4'h1,
    ST_IDCHK = 4'h3,
    ST_XFER = 4'h2,
    ST_ALTSEEK = 4'h6,
    ST_ALTRET = 4'h7,
    ST_CYLSEEK = 4'h5,
    ST_VERIFY = 4'h4,
    ST_FMT = 4'hC,
    ST_DONE = 4'hD
  } seq_state_t;
  typedef logic [15:0] blk_count_t;
endpackage

// ### rtl/data_fifo.sv
// small synchronous fifo with valid/ready on both sides
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // flush
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] level;
  logic doWrite;
  logic doRead;

  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign inReady = (level != (AW+1)'(DEPTH));
  assign outValid = (level != '0);
  assign outData = mem[rdPtr];

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
        level <= level + 1'b1;
      end else if (doRead && !doWrite) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

// ### rtl/replica_pick.sv
// picks the replica copy whose first block lies nearest the head
module replica_pick (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire logic [31:0] firstBlock,
  input wire logic [15:0] perCopy,
  input wire logic [15:0] replCount,
  input wire logic [31:0] headBlock,
  // answer
  output logic done,
  output logic [31:0] bestBlock
);
  logic busy;
  logic [31:0] cand;
  logic [31:0] bestDist;
  logic [15:0] left;

  function automatic logic [31:0] absDiff(input logic [31:0] a, input logic [31:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cand <= '0;
      left <= '0;
      bestBlock <= '0;
      bestDist <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cand <= firstBlock;
        left <= replCount;
        bestBlock <= firstBlock;
        bestDist <= 32'hFFFFFFFF;
      end else if (busy) begin
        if (left < perCopy || perCopy == 16'h0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          if (absDiff(cand, headBlock) < bestDist) begin
            bestDist <= absDiff(cand, headBlock);
            bestBlock <= cand;
          end
          cand <= cand + {16'h0000, perCopy};
          left <= left - perCopy;
        end
      end
    end
  end
endmodule

// ### rtl/fba_transfer_seq.sv
// transfer sequencer for fixed-block disks: positioning, data, verify, alternates
`include "fba_seq_params.svh"

module fba_transfer_seq
  import fba_seq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // positioning command from host
  input wire logic locateValid,
  input wire logic [2:0] locateSub,
  input wire logic [31:0] locateBlock,
  input wire logic [15:0] locateCount,
  input wire logic [15:0] locateReplCount,
  input wire logic [15:0] blockSize,
  // read or write command from host
  input wire logic xferStart,
  input wire logic [31:0] hostByteCount,
  input wire logic chainPoint,
  // host write data
  input wire logic hostWrValid,
  output logic hostWrReady,
  input wire logic [7:0] hostWrData,
  // host read data
  output logic hostRdValid,
  input wire logic hostRdReady,
  output logic [7:0] hostRdData,
  // drive geometry
  input wire logic [31:0] blocksPerCyl,
  input wire logic [31:0] headBlock,
  // drive mechanism
  output logic seekReq,
  output logic [31:0] seekBlock,
  input wire logic seekDone,
  output logic idReadReq,
  input wire logic idValid,
  input wire logic [31:0] idBlock,
  input wire logic idDefective,
  input wire logic [31:0] idAltBlock,
  output logic altSearchReq,
  input wire logic altFound,
  input wire logic altNone,
  input wire logic [31:0] altBlockIn,
  output logic linkWrite,
  output logic [31:0] linkPrimary,
  output logic [31:0] linkAlternate,
  input wire logic linkDone,
  output logic diskWrValid,
  input wire logic diskWrReady,
  output logic [7:0] diskWrData,
  input wire logic diskRdValid,
  input wire logic [7:0] diskRdData,
  input wire logic eccError,
  // status
  output logic busy,
  output logic cmdDone,
  output logic unitCheck,
  output logic opIncomplete,
  output logic overrun,
  output logic sizeReject,
  output logic verifyFail
);
  seq_state_t state;
  seq_state_t next_state;
  logic [2:0] sub;
  logic [31:0] firstBlock;
  logic [31:0] curBlock;
  logic [31:0] resumeBlock;
  blk_count_t blkLeft;
  blk_count_t blkTotal;
  logic [8:0] byteIdx;
  logic [31:0] hostLeft;
  logic onAlt;
  logic pickStart;
  logic pickDone;
  logic [31:0] pickBlock;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [7:0] fifoOutData;
  logic fifoInReady;
  logic fifoFlush;
  logic isWrite;
  logic byteStep;
  logic lastByte;
  logic hostPhase;

  function automatic logic sizeOk(input logic [15:0] sz);
    sizeOk = (sz == `BLOCK_BYTES) || (sz == `BLOCK_BYTES_ZERO);
  endfunction

  function automatic logic cylEnd(input logic [31:0] blk, input logic [31:0] perCyl);
    cylEnd = (perCyl != 32'h00000000) && ((blk + 32'h00000001) % perCyl == 32'h00000000);
  endfunction

  assign isWrite = (sub == `SUB_WRITE) || (sub == `SUB_WRITE_CHECK);
  assign hostPhase = (hostLeft != 32'h00000000);
  assign lastByte = (byteIdx == 9'h1FF);

  // write path: host bytes go through the fifo; padding zeros once host count ends
  data_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) wrFifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inValid(hostWrValid && hostPhase && state == ST_XFER && isWrite),
    .inReady(fifoInReady),
    .inData(hostWrData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData),
    .flush(fifoFlush)
  );

  replica_pick picker (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(pickStart),
    .firstBlock(locateBlock),
    .perCopy(locateCount),
    .replCount(locateReplCount),
    .headBlock(headBlock),
    .done(pickDone),
    .bestBlock(pickBlock)
  );

  assign fifoFlush = (state == ST_IDLE);
  assign fifoOutReady = (state == ST_XFER) && isWrite && hostPhase && diskWrReady && !diskWrValid;

  // a byte moves when the disk side accepts or delivers it, and on a host-phase read only if hostRdData is free or being taken
  always_comb begin
    byteStep = 1'b0;
    if (state == ST_XFER) begin
      if (isWrite) begin
        byteStep = diskWrValid && diskWrReady;
      end else begin
        byteStep = diskRdValid && (!hostPhase || !hostRdValid || hostRdReady);
      end
    end else if (state == ST_VERIFY) begin
      byteStep = diskRdValid;
    end
  end

  logic verifying;

  function automatic logic isWriteVerifyPending();
    isWriteVerifyPending = !verifying;
  endfunction

  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (locateValid && sizeOk(blockSize)) begin
          next_state = (locateSub == `SUB_FORMAT_DEF) ? ST_FMT : ST_SEEK;
        end
      end
      ST_FMT: begin
        if (linkDone) begin
          next_state = ST_DONE;
        end else if (altNone) begin
          next_state = ST_DONE;
        end
      end
      ST_SEEK: begin
        if (seekDone && xferStart) begin
          next_state = ST_IDCHK;
        end
      end
      ST_IDCHK: begin
        if (idValid) begin
          if (idDefective && !onAlt) begin
            next_state = ST_ALTSEEK;
          end else begin
            next_state = ST_XFER;
          end
        end
      end
      ST_ALTSEEK: begin
        if (seekDone) begin
          next_state = ST_IDCHK;
        end
      end
      ST_XFER: begin
        if (byteStep && lastByte) begin
          if (blkLeft == 16'h0001) begin
            next_state = (sub == `SUB_WRITE_CHECK) ? ST_CYLSEEK : ST_DONE;
          end else if (onAlt) begin
            next_state = ST_ALTRET;
          end else if (cylEnd(curBlock, blocksPerCyl)) begin
            next_state = ST_CYLSEEK;
          end else begin
            next_state = ST_IDCHK;
          end
        end
      end
      ST_ALTRET, ST_CYLSEEK: begin
        if (seekDone) begin
          next_state = (sub == `SUB_WRITE_CHECK && !isWriteVerifyPending()) ? ST_VERIFY : ST_IDCHK;
        end
      end
      ST_VERIFY: begin
        if (byteStep && lastByte && blkLeft == 16'h0001) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // positioning and counts
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub <= `SUB_READ;
      firstBlock <= '0;
      curBlock <= '0;
      resumeBlock <= '0;
      blkLeft <= '0;
      blkTotal <= '0;
      byteIdx <= '0;
      hostLeft <= '0;
      onAlt <= 1'b0;
      verifying <= 1'b0;
      pickStart <= 1'b0;
    end else begin
      pickStart <= 1'b0;
      if (state == ST_IDLE && locateValid && sizeOk(blockSize)) begin
        sub <= locateSub;
        firstBlock <= locateBlock;
        curBlock <= locateBlock;
        blkLeft <= locateCount;
        blkTotal <= locateCount;
        onAlt <= 1'b0;
        verifying <= 1'b0;
        byteIdx <= '0;
        pickStart <= (locateSub == `SUB_READ_REPL);
      end
      if (pickDone) begin
        firstBlock <= pickBlock;
        curBlock <= pickBlock;
      end
      if (state == ST_SEEK && xferStart) begin
        hostLeft <= hostByteCount;
      end
      if (state == ST_IDCHK && idValid && idDefective && !onAlt) begin
        resumeBlock <= curBlock + 32'h00000001;
        curBlock <= idAltBlock;
        onAlt <= 1'b1;
      end
      if (byteStep) begin
        byteIdx <= byteIdx + 9'h001;
        if (state == ST_XFER && hostPhase) begin
          hostLeft <= hostLeft - 32'h00000001;
        end
        if (lastByte) begin
          blkLeft <= blkLeft - 16'h0001;
          if (onAlt) begin
            curBlock <= resumeBlock;
            onAlt <= 1'b0;
          end else begin
            curBlock <= curBlock + 32'h00000001;
          end
        end
      end
      if (state == ST_XFER && next_state == ST_CYLSEEK && blkLeft == 16'h0001) begin
        blkLeft <= blkTotal;
        curBlock <= firstBlock;
        verifying <= 1'b1;
      end
    end
  end

  // disk side outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seekReq <= 1'b0;
      seekBlock <= '0;
      idReadReq <= 1'b0;
      altSearchReq <= 1'b0;
      linkWrite <= 1'b0;
      linkPrimary <= '0;
      linkAlternate <= '0;
      diskWrValid <= 1'b0;
      diskWrData <= '0;
    end else begin
      // replicated read seeks only once the nearest copy is known
      seekReq <= ((next_state == ST_SEEK || next_state == ST_ALTSEEK || next_state == ST_ALTRET ||
                   next_state == ST_CYLSEEK) && next_state != state &&
                  !(state == ST_IDLE && locateSub == `SUB_READ_REPL)) || pickDone;
      seekBlock <= pickDone ? pickBlock :
                   (next_state == ST_ALTSEEK) ? idAltBlock :
                   (state == ST_IDLE) ? locateBlock :
                   (next_state == ST_ALTRET) ? resumeBlock :
                   (sub == `SUB_WRITE_CHECK && blkLeft == 16'h0001) ? firstBlock :
                   curBlock + 32'h00000001;
      idReadReq <= (next_state == ST_IDCHK);
      altSearchReq <= (state == ST_IDLE && next_state == ST_FMT);
      if (state == ST_IDLE && locateValid) begin
        linkPrimary <= locateBlock;
      end
      linkWrite <= (state == ST_FMT && altFound && !linkWrite);
      if (state == ST_FMT && altFound) begin
        linkAlternate <= altBlockIn;
      end
      if (diskWrValid && diskWrReady) begin
        diskWrValid <= 1'b0;
      end else if (state == ST_XFER && isWrite && !diskWrValid) begin
        if (hostPhase && fifoOutValid) begin
          diskWrValid <= 1'b1;
          diskWrData <= fifoOutData;
        end else if (!hostPhase) begin
          diskWrValid <= 1'b1;
          diskWrData <= 8'h00;
        end
      end
    end
  end

  // host read data and status
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hostRdValid <= 1'b0;
      hostRdData <= '0;
      hostWrReady <= 1'b0;
      busy <= 1'b0;
      cmdDone <= 1'b0;
      unitCheck <= 1'b0;
      opIncomplete <= 1'b0;
      overrun <= 1'b0;
      sizeReject <= 1'b0;
      verifyFail <= 1'b0;
    end else begin
      hostWrReady <= fifoInReady && hostPhase && state == ST_XFER && isWrite;
      if (hostRdValid && hostRdReady) begin
        hostRdValid <= 1'b0;
      end
      if (state == ST_XFER && !isWrite && byteStep && hostPhase) begin
        hostRdValid <= 1'b1;
        hostRdData <= diskRdData;
      end
      busy <= (next_state != ST_IDLE);
      cmdDone <= (next_state == ST_DONE);
      if (state == ST_IDLE && locateValid) begin
        unitCheck <= !sizeOk(blockSize);
        opIncomplete <= 1'b0;
        overrun <= 1'b0;
        sizeReject <= !sizeOk(blockSize);
        verifyFail <= 1'b0;
      end
      if (state == ST_FMT && altNone && !linkDone) begin
        unitCheck <= 1'b1;
        opIncomplete <= 1'b1;
      end
      if (chainPoint && state == ST_XFER && byteIdx != 9'h000) begin
        overrun <= 1'b1;
        unitCheck <= 1'b1;
      end
      if (state == ST_VERIFY && eccError) begin
        verifyFail <= 1'b1;
        unitCheck <= 1'b1;
      end
    end
  end
endmodule

// ### verif/transfer_seq_sva.sv
// port-level assertions for the transfer sequencer
module transfer_seq_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // host side
  input wire logic locateValid,
  input wire logic [15:0] blockSize,
  input wire logic xferStart,
  input wire logic hostRdValid,
  // drive side
  input wire logic seekReq,
  input wire logic [31:0] seekBlock,
  input wire logic seekDone,
  input wire logic idReadReq,
  input wire logic idValid,
  input wire logic idDefective,
  input wire logic [31:0] idAltBlock,
  input wire logic altNone,
  input wire logic linkDone,
  input wire logic diskWrValid,
  // status
  input wire logic busy,
  input wire logic cmdDone,
  input wire logic unitCheck,
  input wire logic opIncomplete,
  input wire logic sizeReject
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] altLatch;
  // alternate address of the last defective id seen
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      altLatch <= 32'h0;
    end else if (idValid && idDefective) begin
      altLatch <= idAltBlock;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_size_reject;
    locateValid && !busy && blockSize != 16'h0200 && blockSize != 16'h0000 |-> ##[1:2] (sizeReject && unitCheck);
  endproperty
  a_size_reject: assert property (p_size_reject) else $error("size not refused");
  property p_flag_hold;
    sizeReject && !locateValid |=> sizeReject;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("size flag dropped");
  property p_cmd_pulse;
    cmdDone |=> !cmdDone;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("done too long");
  property p_id_req;
    xferStart && seekDone |-> ##[0:4] idReadReq;
  endproperty
  a_id_req: assert property (p_id_req) else $error("no id read");
  property p_id_first;
    xferStart && seekDone |=> (!diskWrValid && !hostRdValid) until_with idValid;
  endproperty
  a_id_first: assert property (p_id_first) else $error("data before id");
  property p_alt_none;
    altNone |-> ##[1:3] (unitCheck && opIncomplete);
  endproperty
  a_alt_none: assert property (p_alt_none) else $error("no incomplete check");
  property p_link_done;
    linkDone |-> ##[1:3] cmdDone;
  endproperty
  a_link_done: assert property (p_link_done) else $error("format not ended");
  property p_alt_seek;
    idValid && idDefective |-> ##[1:4] (seekReq && seekBlock == altLatch);
  endproperty
  a_alt_seek: assert property (p_alt_seek) else $error("no alternate seek");
  property p_quiet_done;
    cmdDone |=> !diskWrValid;
  endproperty
  a_quiet_done: assert property (p_quiet_done) else $error("write after done");
endmodule

// ### verif/disk_model.sv
// behavioural drive mechanism facing the transfer sequencer
module disk_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // scenario controls
  input wire logic [31:0] defBlock,
  input wire logic noAlt,
  input wire logic eccBad,
  // positioning
  input wire logic seekReq,
  input wire logic [31:0] seekBlock,
  output logic seekDone,
  input wire logic idReadReq,
  output logic idValid,
  output logic [31:0] idBlock,
  output logic idDefective,
  output logic [31:0] idAltBlock,
  // alternates
  input wire logic altSearchReq,
  output logic altFound,
  output logic altNone,
  output logic [31:0] altBlockIn,
  input wire logic linkWrite,
  output logic linkDone,
  // data
  output logic diskWrReady,
  output logic diskRdValid,
  output logic [7:0] diskRdData,
  output logic eccError
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ALT_BLOCK = 32'h0000_0384;
  logic [31:0] pos;
  logic [3:0] seekCnt, idCnt, altCnt;
  logic [7:0] rdByte;
  logic [2:0] tick;
  logic reading;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {pos, idBlock, idAltBlock, altBlockIn} <= '0;
      {seekCnt, idCnt, altCnt, rdByte, tick, diskRdData} <= '0;
      {seekDone, idValid, idDefective, altFound, altNone, linkDone} <= '0;
      {diskWrReady, diskRdValid, eccError, reading} <= '0;
    end else begin
      tick <= tick + 3'h1;
      diskWrReady <= (tick != 3'h7);
      seekDone <= (seekCnt == 4'h1);
      if (seekReq) seekCnt <= 4'h4;
      else if (seekCnt != 4'h0) seekCnt <= seekCnt - 4'h1;
      idValid <= (idCnt == 4'h1);
      idBlock <= (idCnt == 4'h1) ? pos : ~idBlock;
      idDefective <= (idCnt == 4'h1) && (pos == defBlock);
      idAltBlock <= (idCnt == 4'h1) ? ALT_BLOCK : ~idAltBlock;
      if (idCnt == 4'h0 && idReadReq && seekCnt == 4'h0) idCnt <= 4'h3;
      else if (idCnt == 4'hF && !idReadReq) idCnt <= 4'h0;
      else if (idCnt == 4'h1) idCnt <= 4'hF;
      else if (idCnt != 4'h0 && idCnt != 4'hF) idCnt <= idCnt - 4'h1;
      if (seekReq) pos <= seekBlock;
      else if (idCnt == 4'h1) pos <= pos + 32'h1;
      if (seekReq) reading <= 1'b0;
      else if (seekDone || idValid) reading <= 1'b1;
      diskRdValid <= reading && tick[0];
      diskRdData <= (reading && tick[0]) ? rdByte : ~diskRdData;
      if (reading && tick[0]) rdByte <= rdByte + 8'h1;
      eccError <= eccBad && reading;
      altFound <= (altCnt == 4'h1) && !noAlt;
      altNone <= (altCnt == 4'h1) && noAlt;
      altBlockIn <= (altCnt == 4'h1) ? ALT_BLOCK : ~altBlockIn;
      if (altSearchReq) altCnt <= 4'h3;
      else if (altCnt != 4'h0) altCnt <= altCnt - 4'h1;
      linkDone <= linkWrite;
    end
  end
endmodule

// ### verif/tb_fixed_block_disk_transfer_sequencer.sv
// self-checking testbench for the fixed-block transfer sequencer
module tb_fixed_block_disk_transfer_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ALT_BLOCK = 32'h0000_0384;
  localparam logic [31:0] NO_CHAIN = 32'hFFFF_FFFF;
  logic sys_clk, reset_n, locateValid, xferStart, chainPoint, hostWrValid, hostWrReady, hostRdValid, hostRdReady;
  logic seekReq, seekDone, idReadReq, idValid, idDefective, altSearchReq, altFound, altNone, linkWrite, linkDone;
  logic diskWrValid, diskWrReady, diskRdValid, eccError, busy, cmdDone, unitCheck, opIncomplete, overrun;
  logic sizeReject, verifyFail, noAlt, eccBad, armed, doneSeen, chainGone;
  logic [2:0] locateSub;
  logic [7:0] hostWrData, hostRdData, diskWrData, diskRdData;
  logic [15:0] locateCount, locateReplCount, blockSize;
  logic [31:0] locateBlock, hostByteCount, blocksPerCyl, headBlock, seekBlock, idBlock, idAltBlock, altBlockIn;
  logic [31:0] linkPrimary, linkAlternate, defBlock, linkP, linkA, chainAt, padFrom;
  logic [31:0] seekLog[$];
  int badCount, testsRun, rdBytes, wrBytes, padBad, cyc;
  fba_transfer_seq uut (.sys_clk, .reset_n, .locateValid, .locateSub, .locateBlock, .locateCount, .locateReplCount,
    .blockSize, .xferStart, .hostByteCount, .chainPoint, .hostWrValid, .hostWrReady, .hostWrData, .hostRdValid,
    .hostRdReady, .hostRdData, .blocksPerCyl, .headBlock, .seekReq, .seekBlock, .seekDone, .idReadReq, .idValid,
    .idBlock, .idDefective, .idAltBlock, .altSearchReq, .altFound, .altNone, .altBlockIn, .linkWrite, .linkPrimary,
    .linkAlternate, .linkDone, .diskWrValid, .diskWrReady, .diskWrData, .diskRdValid, .diskRdData, .eccError, .busy,
    .cmdDone, .unitCheck, .opIncomplete, .overrun, .sizeReject, .verifyFail);
  disk_model drive (.sys_clk, .reset_n, .defBlock, .noAlt, .eccBad, .seekReq, .seekBlock, .seekDone, .idReadReq,
    .idValid, .idBlock, .idDefective, .idAltBlock, .altSearchReq, .altFound, .altNone, .altBlockIn, .linkWrite,
    .linkDone, .diskWrReady, .diskRdValid, .diskRdData, .eccError);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // samples traffic, then drives the host handshakes
  always @(posedge sys_clk) begin
    if (seekReq === 1'b1) seekLog.push_back(seekBlock);
    if (hostRdValid === 1'b1 && hostRdReady) rdBytes++;
    if (diskWrValid === 1'b1 && diskWrReady) begin
      if (diskWrData !== ((wrBytes < padFrom) ? 8'hA5 : 8'h00)) padBad++;
      wrBytes++;
    end
    if (cmdDone === 1'b1) doneSeen = 1'b1;
    if (linkWrite === 1'b1) begin
      linkP = linkPrimary;
      linkA = linkAlternate;
    end
    #2;
    xferStart = armed && seekDone;
    if (xferStart) armed = 1'b0;
    chainPoint = !chainGone && (rdBytes == chainAt);
    if (chainPoint) chainGone = 1'b1;
    hostRdReady = (cyc % 7) != 3;
    cyc++;
  end
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic op(input logic [2:0] sub, input logic [31:0] blk, input logic [15:0] cnt, input logic [15:0] repl,
      input logic [31:0] bytes, input logic [31:0] chain);
    int n;
    seekLog.delete();
    {rdBytes, wrBytes, padBad, n} = '0;
    {doneSeen, chainGone} = 2'h0;
    chainAt = chain;
    padFrom = bytes;
    @(posedge sys_clk);
    #2;
    {locateSub, locateBlock, locateCount, locateReplCount, hostByteCount} = {sub, blk, cnt, repl, bytes};
    locateValid = 1'b1;
    armed = (sub != 3'h4);
    @(posedge sys_clk);
    #2;
    locateValid = 1'b0;
    while (!(doneSeen === 1'b1 || (unitCheck === 1'b1 && busy === 1'b0)) && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(32'h1, n < 20000);
    repeat (20) @(posedge sys_clk);
    #2;
  endtask
  task automatic t_size();
    blockSize = 16'h0100;
    op(3'h0, 32'h5, 16'h1, 16'h0, 32'h200, NO_CHAIN);
    check(32'h1, sizeReject);
    check(32'h1, unitCheck);
    check(32'h0, seekLog.size());
    blockSize = 16'h0000;
  endtask
  task automatic t_read_short();
    op(3'h0, 32'h1E, 16'h2, 16'h0, 32'h258, NO_CHAIN);
    check(32'h258, rdBytes);
    check(32'h1, doneSeen);
    check(32'h1E, seekLog[0]);
  endtask
  task automatic t_read_long();
    blockSize = 16'h0200;
    op(3'h0, 32'h28, 16'h1, 16'h0, 32'h1000, NO_CHAIN);
    check(32'h200, rdBytes);
    check(32'h1, doneSeen);
    blockSize = 16'h0000;
  endtask
  task automatic t_chain();
    op(3'h0, 32'h28, 16'h1, 16'h0, 32'h200, 32'h64);
    check(32'h1, overrun);
  endtask
  task automatic t_defect();
    defBlock = 32'h15;
    op(3'h0, 32'h14, 16'h3, 16'h0, 32'h600, NO_CHAIN);
    check(ALT_BLOCK, seekLog[1]);
    check(32'h16, seekLog[2]);
    check(32'h600, rdBytes);
    defBlock = 32'hFFFF_FFFF;
  endtask
  task automatic t_write_cyl();
    blocksPerCyl = 32'h4;
    op(3'h1, 32'h3, 16'h2, 16'h0, 32'h64, NO_CHAIN);
    check(32'h400, wrBytes);
    check(32'h0, padBad);
    check(32'h4, seekLog[1]);
    blocksPerCyl = 32'h3E8;
  endtask
  task automatic t_write_check();
    eccBad = 1'b1;
    op(3'h2, 32'h32, 16'h1, 16'h0, 32'h200, NO_CHAIN);
    check(32'h32, seekLog[seekLog.size() - 1]);
    check(32'h0, rdBytes);
    check(32'h1, verifyFail);
    eccBad = 1'b0;
  endtask
  task automatic t_repl();
    headBlock = 32'hF;
    op(3'h3, 32'hA, 16'h2, 16'h6, 32'h400, NO_CHAIN);
    check(32'hE, seekLog[0]);
    check(32'h400, rdBytes);
  endtask
  task automatic t_format();
    op(3'h4, 32'h3C, 16'h1, 16'h0, 32'h0, NO_CHAIN);
    check(32'h3C, linkP);
    check(ALT_BLOCK, linkA);
    check(32'h1, doneSeen);
    noAlt = 1'b1;
    op(3'h4, 32'h3D, 16'h1, 16'h0, 32'h0, NO_CHAIN);
    check(32'h1, opIncomplete);
    check(32'h1, unitCheck);
    noAlt = 1'b0;
  endtask
  task automatic summarize();
    if (badCount == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {reset_n, locateValid, xferStart, chainPoint, noAlt, eccBad, armed, doneSeen, chainGone} = '0;
    {locateSub, locateBlock, locateCount, locateReplCount, hostByteCount, blockSize} = '0;
    {badCount, testsRun, rdBytes, wrBytes, padBad, cyc} = '0;
    {linkP, linkA, padFrom} = '0;
    hostWrValid = 1'b1;
    hostWrData = 8'hA5;
    hostRdReady = 1'b1;
    blocksPerCyl = 32'h3E8;
    headBlock = 32'h0;
    defBlock = 32'hFFFF_FFFF;
    chainAt = NO_CHAIN;
    repeat (10) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_size();
    t_read_short();
    t_read_long();
    t_chain();
    t_defect();
    t_write_cyl();
    t_write_check();
    t_repl();
    t_format();
    summarize();
  end
  initial begin
    #5000000;
    badCount++;
    summarize();
  end
endmodule
bind fba_transfer_seq transfer_seq_sva chk (.sys_clk, .reset_n, .locateValid, .blockSize, .xferStart, .hostRdValid,
  .seekReq, .seekBlock, .seekDone, .idReadReq, .idValid, .idDefective, .idAltBlock, .altNone, .linkDone,
  .diskWrValid, .busy, .cmdDone, .unitCheck, .opIncomplete, .sizeReject);
